// File: acr_params.svh
// Purpose: Named constants of the converter readout control
// Assumes: System clock of 10 MHz
// Notes:   Cycle counts derive from ns times
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// =====================================================================
// Widths and encodings
`define ACR_RES_W     12
`define ACR_NBITS     4'hc
`define ACR_CNT_W     16
`define ACR_LOW_NIB   4'h0
`define ACR_CH0       2'h0
`define ACR_CH_STEP   2'h1
`define ACR_PIN_W     9

// =====================================================================
// Times and derived cycle counts
`define ACR_CLK_NS       100
`define ACR_START_MIN_NS 40
`define ACR_CONV_NS      15000
`define ACR_SCLK_NS      1100
`define ACR_START_CYC \
    ((`ACR_START_MIN_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_CONV_CYC  (`ACR_CONV_NS / `ACR_CLK_NS)
`define ACR_HALF_CYC  ((`ACR_SCLK_NS / 2) / `ACR_CLK_NS)

`endif

// File: acr_pkg.sv
// Purpose: Types of the converter readout control
// Assumes: Nothing
// Notes:   Widths follow acr_params.svh
`include "acr_params.svh"

package acr_pkg;

    // =================================================================
    // Result word with the channel it came from
    typedef struct packed {
        logic [`ACR_RES_W-1:0] code;
        logic [1:0]            chan;
    } acr_word_t;

    // Control pins as synchronised
    typedef struct packed {
        logic select_n;
        logic read_convert_n;
        logic half_word_pick;
        logic output_format_pick;
        logic clock_source_pick;
        logic auto_scan;
        logic sleep_req;
        logic chain_in;
        logic shift_clock;
    } acr_pins_t;

    typedef enum logic [1:0] {
        ACR_IDLE,
        ACR_ARM,
        ACR_CONV
    } acr_state_t;

endpackage

// File: acr_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are asynchronous levels
// Notes:   Only the second stage is read
`timescale 1ns/1ps
`default_nettype none

module acr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_meta = d_i;
        next_q    = meta;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end

endmodule

`default_nettype wire

// File: acr_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock
// Notes:   in_ready_o low only when full
`timescale 1ns/1ps
`default_nettype none

module acr_buf2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    logic [WIDTH-1:0] mem [2];
    logic [WIDTH-1:0] next_mem [2];
    logic             wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0]       count, next_count;
    logic             push, pop;

    always_comb begin
        in_ready_o  = (count != 2'h2);
        out_valid_o = (count != 2'h0);
        out_data_o  = mem[rd_ptr];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = in_data_i;
            next_wr_ptr      = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        mem <= next_mem;
    end

endmodule

`default_nettype wire

// File: acr_ctrl.sv
// Purpose: Conversion start, busy and result readout of a 12-bit
//          four-channel sampling converter (parallel and serial)
// Assumes: All pins asynchronous to CLK_SYS_I; SAMPLE_I is on-chip
// Notes:   Analog core is modelled by a cycle counter and SAMPLE_I
//
// Contract
// [RULE1] Both start inputs low 40ns starts conversion
// [RULE2] Busy low from start until result stored
// [RULE3] Start requests ignored while busy low
// [RULE4] Host releases a start input before busy rises
// [RULE5] Inputs ORed by level; either may fall first
// [RULE6] Host spaces conversions 25us for acquisition
// [RULE7] Parallel bus driven only selected and reading
// [RULE8] Half pick chooses upper eight or low nibble
// [RULE9] Toggling half pick switches bus contents
// [RULE10] Bus shows new result when busy rises
// [RULE11] Two's complement, serial MSB first
// [RULE12] Internal clock: start shifts previous 12 bits
// [RULE13] Internal clock: busy waits for transmission end
// [RULE14] Select tied low: read_convert_n alone controls
// [RULE15] External clock: chain_in reappears 12 cycles later
// [RULE16] Busy rise loads serial register; clock low
// [RULE17] External read enable sends frame then result
// [RULE18] External read enable activates output, clock shifts
// [RULE19] Continuous scan restarts and transmits each conversion
// [RULE20] Serial mode tri-states per clock source
// [RULE21] Output format high parallel, low serial
// [RULE22] Clock source low internal, high external
// [RULE23] Auto scan steps channels while starts held low; code steps only in serial mode
// [RULE24] Sleep blocks conversions, scan channel returns zero
// [RULE25] Conversion time is a parameterised counter
// [RULE26] Result unknown until first conversion completes
`include "acr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module acr_ctrl #(
    parameter int CONV_CYCLES = `ACR_CONV_CYC
) (
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RST_I,
    input  wire logic                  SELECT_N_I,
    input  wire logic                  READ_CONVERT_N_I,
    input  wire logic                  HALF_WORD_PICK_I,
    input  wire logic                  OUTPUT_FORMAT_PICK_I,
    input  wire logic                  CLOCK_SOURCE_PICK_I,
    input  wire logic                  AUTO_SCAN_I,
    input  wire logic                  SLEEP_REQ_I,
    input  wire logic                  CHAIN_IN_I,
    input  wire logic                  SHIFT_CLOCK_I,
    input  wire logic [`ACR_RES_W-1:0] SAMPLE_I,
    output logic                       BUSY_N_O,
    output logic      [7:0]            RESULT_BUS_O,
    output logic      [7:0]            RESULT_BUS_OE_O,
    output logic                       SERIAL_OUT_O,
    output logic                       SERIAL_OUT_OE_O,
    output logic                       SHIFT_CLOCK_O,
    output logic                       SHIFT_CLOCK_OE_O,
    output logic                       FRAME_PULSE_O,
    output logic      [1:0]            CHANNEL_O
);
    import acr_pkg::*;

    localparam logic [`ACR_CNT_W-1:0] CONV_N =
        `ACR_CNT_W'(CONV_CYCLES - 1);
    localparam logic [`ACR_CNT_W-1:0] START_N =
        `ACR_CNT_W'(`ACR_START_CYC - 1);
    localparam logic [`ACR_CNT_W-1:0] HALF_N =
        `ACR_CNT_W'(`ACR_HALF_CYC - 1);

    // =================================================================
    // Pin synchronisation
    acr_pins_t pins_raw, pin;

    assign pins_raw = '{select_n:           SELECT_N_I,
                        read_convert_n:     READ_CONVERT_N_I,
                        half_word_pick:     HALF_WORD_PICK_I,
                        output_format_pick: OUTPUT_FORMAT_PICK_I,
                        clock_source_pick:  CLOCK_SOURCE_PICK_I,
                        auto_scan:          AUTO_SCAN_I,
                        sleep_req:          SLEEP_REQ_I,
                        chain_in:           CHAIN_IN_I,
                        shift_clock:        SHIFT_CLOCK_I};

    acr_sync #(
        .WIDTH ($bits(acr_pins_t))
    ) u_sync (
        .clk_i (CLK_SYS_I),
        .rst_i (RST_I),
        .d_i   (pins_raw),
        .q_o   (pin)
    );

    // =================================================================
    // Decoded modes
    logic par_mode, int_ser, ext_ser, start_lvl, read_en;

    always_comb begin
        par_mode  = pin.output_format_pick;                  // [RULE21]
        int_ser   = !par_mode && !pin.clock_source_pick;     // [RULE22]
        ext_ser   = !par_mode && pin.clock_source_pick;      // [RULE22]
        start_lvl = !pin.select_n && !pin.read_convert_n
                    && !pin.sleep_req;             // [RULE1] [RULE5]
        read_en   = !pin.select_n && pin.read_convert_n; // [RULE14]
    end

    // =================================================================
    // Conversion sequencer, serial engines and pin drivers
    acr_state_t              state, next_state;
    logic [`ACR_CNT_W-1:0]   cnt, next_cnt;
    acr_word_t               hold_word, next_hold_word;
    logic [1:0]              chan, next_chan;
    logic [`ACR_RES_W-1:0]   tx_sreg, next_tx_sreg;
    logic [3:0]              tx_left, next_tx_left;
    logic [`ACR_CNT_W-1:0]   div, next_div;
    logic                    sclk, next_sclk;
    logic [`ACR_RES_W-1:0]   ext_sreg, next_ext_sreg;
    logic                    sclk_d, next_sclk_d;
    logic                    read_en_d, next_read_en_d;
    logic                    frame, next_frame;
    logic                    busy, next_busy;
    logic [7:0]              bus, next_bus;
    logic [7:0]              bus_oe, next_bus_oe;
    logic                    sout, next_sout;
    logic                    sout_oe, next_sout_oe;
    logic                    push, in_ready, out_valid, out_ready;
    acr_word_t               out_word;
    acr_word_t               result, next_result;
    logic                    tx_busy, ext_rise;

    acr_buf2 #(
        .WIDTH ($bits(acr_word_t))
    ) u_buf (
        .clk_i       (CLK_SYS_I),
        .rst_i       (RST_I),
        .in_valid_i  (push),
        .in_ready_o  (in_ready),
        .in_data_i   (hold_word),
        .out_valid_o (out_valid),
        .out_ready_i (out_ready),
        .out_data_o  (out_word)
    );

    always_comb begin
        tx_busy  = (tx_left != 4'h0);
        ext_rise = pin.shift_clock && !sclk_d;
        push     = (state == ACR_CONV) && (cnt == '0);
        // Store after transmission, link clock low
        out_ready = !tx_busy
                    && !(ext_ser && pin.shift_clock); // [RULE13] [RULE16]

        next_state     = state;
        next_cnt       = cnt;
        next_hold_word = hold_word;
        next_chan      = chan;
        next_tx_sreg   = tx_sreg;
        next_tx_left   = tx_left;
        next_div       = div;
        next_sclk      = sclk;
        next_ext_sreg  = ext_sreg;
        next_frame     = frame;
        next_result    = result;
        next_sclk_d    = pin.shift_clock;
        next_read_en_d = read_en;

        unique case (state)
            ACR_IDLE: begin
                // Start only with no result pending
                if (start_lvl && !busy) begin        // [RULE3]
                    next_state = ACR_ARM;
                    next_cnt   = START_N;
                end
            end
            ACR_ARM: begin
                if (!start_lvl) begin
                    next_state = ACR_IDLE;
                end else if (cnt == '0) begin         // [RULE1]
                    next_state     = ACR_CONV;
                    next_cnt       = CONV_N;          // [RULE25]
                    next_hold_word = '{code: SAMPLE_I, chan: chan};
                    if (pin.auto_scan && !par_mode) begin
                        next_chan = chan + `ACR_CH_STEP;  // [RULE23]
                    end
                    if (int_ser) begin
                        // Previous result leaves MSB first
                        next_tx_sreg = result.code;   // [RULE12] [RULE19]
                        next_tx_left = `ACR_NBITS;    // [RULE11]
                        next_div     = HALF_N;
                        next_sclk    = 1'b0;
                    end
                end else begin
                    next_cnt = cnt - `ACR_CNT_W'(1);
                end
            end
            ACR_CONV: begin
                if (cnt != '0) begin
                    next_cnt = cnt - `ACR_CNT_W'(1);
                end else if (in_ready) begin
                    next_state = ACR_IDLE;
                end
            end
        endcase

        if (pin.sleep_req && pin.auto_scan) begin
            next_chan = `ACR_CH0;                         // [RULE24]
        end

        // Internal shift clock: 12 pulses, shift on each fall
        if (tx_busy) begin
            if (div == '0) begin
                next_div  = HALF_N;
                next_sclk = !sclk;
                if (sclk) begin
                    next_tx_sreg = {tx_sreg[`ACR_RES_W-2:0], 1'b0};
                    next_tx_left = tx_left - 4'h1;    // [RULE12]
                end
            end else begin
                next_div = div - `ACR_CNT_W'(1);
            end
        end

        // External clock: frame, then chain shift
        if (ext_ser && read_en && !read_en_d) begin
            next_frame = 1'b1;                        // [RULE17]
        end else if (ext_rise) begin
            next_frame = 1'b0;
        end
        if (ext_ser && read_en && ext_rise && !frame) begin
            next_ext_sreg = {ext_sreg[`ACR_RES_W-2:0],
                             pin.chain_in};          // [RULE15] [RULE18]
        end

        // Result store marks the end of busy
        if (out_valid && out_ready) begin
            next_result   = out_word;                 // [RULE2] [RULE10]
            next_ext_sreg = out_word.code;            // [RULE16]
        end

        next_busy = (next_state == ACR_CONV) || push || out_valid
                    || (next_tx_left != 4'h0);         // [RULE2] [RULE13]

        // Parallel bus drivers
        next_bus_oe = {8{par_mode && read_en}};       // [RULE7] [RULE14]
        if (pin.half_word_pick) begin
            next_bus = {next_result.code[3:0], `ACR_LOW_NIB}; // [RULE8]
        end else begin
            next_bus = next_result.code[11:4];        // [RULE8] [RULE9]
        end

        // Serial data pin
        if (ext_ser) begin
            next_sout    = next_ext_sreg[`ACR_RES_W-1];
            next_sout_oe = read_en;                   // [RULE18]
        end else begin
            next_sout    = next_tx_sreg[`ACR_RES_W-1];
            next_sout_oe = int_ser && next_busy;      // [RULE20]
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state     <= ACR_IDLE;
            cnt       <= '0;
            hold_word <= '0;
            chan      <= `ACR_CH0;
            tx_sreg   <= '0;
            tx_left   <= 4'h0;
            div       <= '0;
            sclk      <= 1'b0;
            ext_sreg  <= '0;
            sclk_d    <= 1'b0;
            read_en_d <= 1'b0;
            frame     <= 1'b0;
            busy      <= 1'b0;
            bus_oe    <= 8'h00;
            sout_oe   <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            hold_word <= next_hold_word;
            chan      <= next_chan;
            tx_sreg   <= next_tx_sreg;
            tx_left   <= next_tx_left;
            div       <= next_div;
            sclk      <= next_sclk;
            ext_sreg  <= next_ext_sreg;
            sclk_d    <= next_sclk_d;
            read_en_d <= next_read_en_d;
            frame     <= next_frame;
            busy      <= next_busy;
            bus_oe    <= next_bus_oe;
            sout_oe   <= next_sout_oe;
        end
    end

    // Result data unknown until the first conversion
    always_ff @(posedge CLK_SYS_I) begin
        result <= next_result;                        // [RULE26]
        bus    <= next_bus;
        sout   <= next_sout;
    end

    // =================================================================
    // Outputs
    always_comb begin
        BUSY_N_O         = !busy;                     // [RULE2]
        RESULT_BUS_O     = bus;
        RESULT_BUS_OE_O  = bus_oe;
        SERIAL_OUT_O     = sout;
        SERIAL_OUT_OE_O  = sout_oe;
        SHIFT_CLOCK_O    = sclk;
        SHIFT_CLOCK_OE_O = int_ser;                   // [RULE20]
        FRAME_PULSE_O    = frame && ext_ser;          // [RULE17]
        CHANNEL_O        = chan;
    end

endmodule

`default_nettype wire

// File: acr_ctrl_assertions.sv
// Purpose: Port-level checks of the converter readout control
// Assumes: Pins pass a two-flop synchroniser; shift clock 5+5 cycles
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module acr_ctrl_assertions #(
    parameter int CONV_CYCLES = 150
) (
    input wire logic       CLK_SYS_I,
    input wire logic       RST_I,
    input wire logic       SELECT_N_I,
    input wire logic       READ_CONVERT_N_I,
    input wire logic       HALF_WORD_PICK_I,
    input wire logic       OUTPUT_FORMAT_PICK_I,
    input wire logic       CLOCK_SOURCE_PICK_I,
    input wire logic       AUTO_SCAN_I,
    input wire logic       SLEEP_REQ_I,
    input wire logic       BUSY_N_O,
    input wire logic [7:0] RESULT_BUS_O,
    input wire logic [7:0] RESULT_BUS_OE_O,
    input wire logic       SERIAL_OUT_OE_O,
    input wire logic       SHIFT_CLOCK_O,
    input wire logic       SHIFT_CLOCK_OE_O,
    input wire logic       FRAME_PULSE_O,
    input wire logic [1:0] CHANNEL_O
);
    logic [1:0]  up;
    logic [1:0]  next_up;
    logic [15:0] low_cnt;
    logic [15:0] next_low_cnt;

    // =================================================================
    // Settling count after reset and length of the busy phase
    always_comb begin
        next_up = (up == 2'h3) ? up : up + 2'h1;
        next_low_cnt = BUSY_N_O ? 16'h0 : low_cnt + 16'h1;
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            up <= 2'h0;
            low_cnt <= 16'h0;
        end else begin
            up <= next_up;
            low_cnt <= next_low_cnt;
        end
    end

    default clocking @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    // =================================================================
    // Checks
    busy_fall_a: assert property (
        up == 2'h3 && $fell(BUSY_N_O) |->
        $past(!SELECT_N_I && !READ_CONVERT_N_I && !SLEEP_REQ_I, 3))
        else $error("busy fell without a start request");
    busy_len_a: assert property (
        $rose(BUSY_N_O) |-> low_cnt >= CONV_CYCLES)
        else $error("busy low shorter than the conversion");
    chan_hold_a: assert property (
        !BUSY_N_O && !$past(BUSY_N_O) |-> $stable(CHANNEL_O))
        else $error("start taken while busy");
    bus_oe_a: assert property (
        up == 2'h3 && RESULT_BUS_OE_O != 8'h00 |-> RESULT_BUS_OE_O == 8'hff
        && $past(!SELECT_N_I && READ_CONVERT_N_I && OUTPUT_FORMAT_PICK_I, 3))
        else $error("parallel bus driven outside a read");
    low_nib_a: assert property (
        RESULT_BUS_OE_O == 8'hff && $past(HALF_WORD_PICK_I, 3)
        && $past(HALF_WORD_PICK_I, 4) |-> RESULT_BUS_O[3:0] == 4'h0)
        else $error("low nibble not driven low");
    sck_oe_a: assert property (
        up == 2'h3 |-> SHIFT_CLOCK_OE_O ==
        $past(!OUTPUT_FORMAT_PICK_I && !CLOCK_SOURCE_PICK_I, 2))
        else $error("shift clock enable does not follow mode");
    sck_busy_a: assert property (
        SHIFT_CLOCK_O |-> !BUSY_N_O)
        else $error("shift clock pulse while not busy");
    sck_half_a: assert property (
        $rose(SHIFT_CLOCK_O) |-> SHIFT_CLOCK_O[*5] ##1 !SHIFT_CLOCK_O)
        else $error("shift clock high phase not five cycles");
    frame_oe_a: assert property (
        FRAME_PULSE_O |-> SERIAL_OUT_OE_O)
        else $error("frame pulse with serial output off");
    sleep_chan_a: assert property (
        $past(SLEEP_REQ_I, 4) && $past(SLEEP_REQ_I, 5)
        && $past(AUTO_SCAN_I, 4) |-> CHANNEL_O == 2'h0)
        else $error("channel not back at zero in sleep");
endmodule

bind acr_ctrl acr_ctrl_assertions #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
    .CLK_SYS_I, .RST_I, .SELECT_N_I, .READ_CONVERT_N_I, .HALF_WORD_PICK_I,
    .OUTPUT_FORMAT_PICK_I, .CLOCK_SOURCE_PICK_I, .AUTO_SCAN_I,
    .SLEEP_REQ_I, .BUSY_N_O, .RESULT_BUS_O, .RESULT_BUS_OE_O,
    .SERIAL_OUT_OE_O, .SHIFT_CLOCK_O, .SHIFT_CLOCK_OE_O, .FRAME_PULSE_O,
    .CHANNEL_O
);
`default_nettype wire

// File: acr_host.sv
// Purpose: Host side of the serial link: capture and external clock
// Assumes: External clock period 800 ns, low outside frames
// Notes:   Each finished word toggles tog
`timescale 1ns/1ps
`default_nettype none

module acr_host (
    input  wire logic        sck_w,
    input  wire logic        sd_w,
    input  wire logic        ext_mode,
    input  wire logic        go,
    input  wire logic [11:0] pat,
    output logic             sck_drv,
    output logic             chain,
    output logic [23:0]      word,
    output logic             tog
);
    logic [23:0] sh;
    int          nb;

    initial begin
        sck_drv = 1'b0;
        chain = 1'b0;
        word = 24'h0;
        tog = 1'b0;
        sh = 24'h0;
        nb = 0;
    end

    // =================================================================
    // Device clock: MSB first, twelve bits a word
    always @(posedge sck_w) begin
        if (!ext_mode) begin
            sh = {sh[22:0], sd_w};
            nb = nb + 1;
            if (nb == 12) begin
                word = {12'h0, sh[11:0]};
                tog = ~tog;
                nb = 0;
            end
        end
    end

    // =================================================================
    // Own clock: frame rise, then 24 bits
    always @(posedge go) begin
        #33;
        for (int k = 0; k < 25; k++) begin
            #400 sck_drv = 1'b1;
            if (k > 0)
                sh = {sh[22:0], sd_w};
            #400 sck_drv = 1'b0;
            if (k < 12)
                chain = pat[11-k];
        end
        word = sh;
        tog = ~tog;
    end
endmodule
`default_nettype wire

// File: adc_conversion_readout_control_bench.sv
// Purpose: Self-checking bench of the converter readout control
// Assumes: Short conversion count; host model on the link
// Notes:   Drivers queue notes, watchers compare
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_readout_control_bench;
    import acr_pkg::*;
    localparam int CONV = 20;
    logic        clk, rst, go, snap, pbusy;
    acr_pins_t   p;
    logic [11:0] smp, pat, last;
    logic        h_sck, h_chain, h_tog, busy_n, sdo, sdo_oe;
    logic        sck_o, sck_oe, frame;
    logic [23:0] h_word;
    logic [7:0]  bus, bus_oe;
    logic [1:0]  chan;
    wire         sck_w = sck_oe ? sck_o : h_sck;
    wire         sd_w = sdo_oe ? sdo : ~sdo;
    logic [23:0] exp_q[$];
    int          err_total, total_checks, cyc, seed;

    always #50 clk = ~clk;

    acr_ctrl #(.CONV_CYCLES(CONV)) dut_u (
        .CLK_SYS_I(clk), .RST_I(rst), .SELECT_N_I(p.select_n),
        .READ_CONVERT_N_I(p.read_convert_n),
        .HALF_WORD_PICK_I(p.half_word_pick),
        .OUTPUT_FORMAT_PICK_I(p.output_format_pick),
        .CLOCK_SOURCE_PICK_I(p.clock_source_pick),
        .AUTO_SCAN_I(p.auto_scan), .SLEEP_REQ_I(p.sleep_req),
        .CHAIN_IN_I(h_chain), .SHIFT_CLOCK_I(sck_w), .SAMPLE_I(smp),
        .BUSY_N_O(busy_n), .RESULT_BUS_O(bus), .RESULT_BUS_OE_O(bus_oe),
        .SERIAL_OUT_O(sdo), .SERIAL_OUT_OE_O(sdo_oe), .SHIFT_CLOCK_O(sck_o),
        .SHIFT_CLOCK_OE_O(sck_oe), .FRAME_PULSE_O(frame), .CHANNEL_O(chan)
    );
    acr_host host_u (
        .sck_w(sck_w), .sd_w(sd_w), .ext_mode(p.clock_source_pick),
        .go(go), .pat(pat), .sck_drv(h_sck), .chain(h_chain),
        .word(h_word), .tog(h_tog)
    );

    // =================================================================
    // Comparison, waiting and closing
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic take(input logic [23:0] seen);
        check(seen, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    endtask
    task end_of_test();
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task wait_busy(input logic lvl);
        for (int n = 0; n < 400 && busy_n !== lvl; n++)
            step(1);
    endtask
    task conv(input logic sel_first);
        step(250);
        if (sel_first)
            p.select_n = 1'b0;
        else
            p.read_convert_n = 1'b0;
        step(1);
        p.select_n = 1'b0;
        p.read_convert_n = 1'b0;
        step(3);
        p.read_convert_n = 1'b1;
    endtask

    // =================================================================
    // Watchers: bus and host words
    always @(negedge clk) begin
        if ((busy_n && !pbusy && bus_oe === 8'hff) || snap)
            take({16'h0, bus});
        pbusy = busy_n;
    end
    always @(h_tog)
        if (!rst)
            take(h_word);
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        {clk, go, snap, pbusy, rst} = 5'h03;
        p = '0;
        {p.select_n, p.read_convert_n, p.output_format_pick} = 3'h7;
        seed = 32'hc6d0;
        smp = 12'($random(seed));
        pat = 12'h0;
        repeat (20) @(posedge clk);
        #10 rst = 1'b0;
        // Parallel: conversion, refused start, two bytes
        last = smp;
        exp_q.push_back({16'h0, smp[11:4]});
        conv(1'b1);
        wait_busy(1'b0);
        smp = 12'($random(seed));
        p.read_convert_n = 1'b0;
        step(3);
        p.read_convert_n = 1'b1;
        wait_busy(1'b1);
        p.half_word_pick = 1'b1;
        exp_q.push_back({16'h0, last[3:0], 4'h0});
        step(4);
        snap = 1'b1;
        step(1);
        {snap, p.select_n, p.half_word_pick} = 3'h2;
        step(5);
        check({16'h0, bus_oe}, 24'h0);
        // Internal clock: start sends previous word
        p.output_format_pick = 1'b0;
        for (int i = 0; i < 2; i++) begin
            exp_q.push_back({12'h0, last});
            smp = 12'($random(seed));
            last = smp;
            conv(i[0]);
            wait_busy(1'b0);
            wait_busy(1'b1);
            p.select_n = 1'b1;
        end
        // External clock: frame, last word, chain pattern
        p.clock_source_pick = 1'b1;
        pat = 12'($random(seed));
        exp_q.push_back({last, pat});
        step(4);
        p.select_n = 1'b0;
        step(4);
        check({23'h0, frame}, 24'h1);
        go = 1'b1;
        step(210);
        {go, p.select_n, p.clock_source_pick} = 3'h2;
        // Scan: three conversions, then sleep
        p.auto_scan = 1'b1;
        exp_q.push_back({12'h0, last});
        smp = 12'($random(seed));
        repeat (2) exp_q.push_back({12'h0, smp});
        step(4);
        {p.select_n, p.read_convert_n} = 2'h0;
        repeat (3) begin
            wait_busy(1'b1);
            wait_busy(1'b0);
        end
        p.read_convert_n = 1'b1;
        wait_busy(1'b1);
        check({22'h0, chan}, 24'h3);
        p.sleep_req = 1'b1;
        step(6);
        check({22'h0, chan}, 24'h0);
        p.read_convert_n = 1'b0;
        step(10);
        check({23'h0, busy_n}, 24'h1);
        p.read_convert_n = 1'b1;
        step(4);
        p.sleep_req = 1'b0;
        step(20);
        check(24'(exp_q.size()), 24'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
